// ---- include/csd_map.svh ----
// Constants for the changer status and diagnostic responder.
// Assumes inclusion by the package and the design modules only.
// Operation
// - Opcode 1Ch selects diagnostic results return.
// - Allocation length bytes 3-4; zero is legal.
// - Stop data-in at smaller of two counts.
// - Return only after send-diagnostic completed.
// - Page 00h header, reserved, length 6h.
// - List pages 00h,80h,81h,82h,83h,84h ascending.
// - Element address MSB byte 0, LSB byte 1.
// - Access bit follows drive door open.
// - Exception bit reports abnormal mover state.
// - Full bit shows cartridge presence; the code forces it to zero while the mover is faulted.
// - Sense code and qualifier in bytes 4-5.
// - Off-bus, ID, LUN, bus address, invert zero.
// - Source valid flag in byte 9 bit 7.
// - Source slot address bytes 10-11, MSB first.
// - Code 90h qualifiers 02 and 03 defined.
`ifndef CSD_MAP_SVH
`define CSD_MAP_SVH
`define CSD_OP_RDIAG 8'h1c
`define CSD_CDB_LEN 3'd6
`define CSD_CDB_ALLOC_HI 3'd3
`define CSD_CDB_ALLOC_LO 3'd4
`define CSD_SUP_LEN 16'h000a
`define CSD_SUP_PAGE_LEN 8'h06
`define CSD_DESC_LEN 5'd16
`define CSD_DB_ADDR_HI 4'h0
`define CSD_DB_ADDR_LO 4'h1
`define CSD_DB_FLAGS 4'h2
`define CSD_DB_ASC 4'h4
`define CSD_DB_ASCQ 4'h5
`define CSD_DB_SRC_FLAGS 4'h9
`define CSD_DB_SRC_HI 4'ha
`define CSD_DB_SRC_LO 4'hb
`define CSD_ASC_CHS 8'h90
`define CSD_ASCQ_NO_HOLDER 8'h02
`define CSD_ASCQ_QUESTION 8'h03
`define CSD_ADDR_CTRL 4'h0
`define CSD_ADDR_STAT 4'h4
`define CSD_ADDR_INT_STAT 4'h8
`define CSD_ADDR_INT_MASK 4'hc
`define CSD_INT_DONE 0
`define CSD_INT_REJECT 1
`define CSD_RESP_OKAY 2'b00
`define CSD_RESP_SLVERR 2'b10
`endif

// ---- include/csd_pkg.sv ----
// Types for the changer status and diagnostic responder.
// Assumes the constant header is on the include path.
`include "csd_map.svh"
package csd_pkg;
  typedef enum logic [1:0] {
    CSD_IDLE,
    CSD_CMD,
    CSD_DATA
  } csd_state_t;
  typedef logic [7:0] csd_byte_t;
endpackage

// ---- hw/csd_desc.sv ----
// Drive element descriptor byte selector.
// Assumes status inputs are stable while the descriptor is read.
`include "csd_map.svh"
module csd_desc
(
  input wire logic [3:0] idx,
  input wire logic [15:0] elem_addr,
  input wire logic door_open,
  input wire logic mover_fault,
  input wire logic full,
  input wire logic [7:0] asc,
  input wire logic [7:0] ascq,
  input wire logic src_valid,
  input wire logic [15:0] src_addr,
  output csd_pkg::csd_byte_t data
);
  import csd_pkg::*;

  always_comb
  begin
    data = 8'h00;
    case (idx)
      `CSD_DB_ADDR_HI: data = elem_addr[15:8];
      `CSD_DB_ADDR_LO: data = elem_addr[7:0];
      // Full is only reported while the mover is normal.
      `CSD_DB_FLAGS: data = {4'h0, door_open, mover_fault, 1'b0,
                             full & ~mover_fault};
      `CSD_DB_ASC: data = mover_fault ? asc : 8'h00;
      `CSD_DB_ASCQ: data = mover_fault ? ascq : 8'h00;
      `CSD_DB_SRC_FLAGS: data = {src_valid, 7'h00};
      `CSD_DB_SRC_HI: data = src_addr[15:8];
      `CSD_DB_SRC_LO: data = src_addr[7:0];
      default: data = 8'h00;
    endcase
  end
endmodule

// ---- hw/csd_top.sv ----
// Diagnostic results command interpreter with descriptor readout.
// Assumes one clock; command bytes and data-in use valid/ready.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`include "csd_map.svh"
module csd_top
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CDB_VALID,
  input wire logic [7:0] CDB_BYTE,
  output logic CDB_READY,
  output logic DIN_VALID,
  output csd_pkg::csd_byte_t DIN_DATA,
  output logic DIN_LAST,
  input wire logic DIN_READY,
  output logic CMD_DONE,
  output logic CMD_REJECT,
  input wire logic SENDDIAG_DONE,
  input wire logic [7:0] SENDDIAG_PAGE,
  input wire logic DESC_REQ,
  input wire logic [3:0] DESC_IDX,
  output csd_pkg::csd_byte_t DESC_DATA,
  input wire logic [15:0] ELEM_ADDR,
  input wire logic DOOR_OPEN,
  input wire logic MOVER_FAULT,
  input wire logic CART_PRESENT,
  input wire logic [7:0] FAULT_ASC,
  input wire logic [7:0] FAULT_ASCQ,
  input wire logic SRC_VALID,
  input wire logic [15:0] SRC_ADDR,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic IRQ
);
  import csd_pkg::*;

  csd_state_t state;
  logic [2:0] cdb_cnt;
  logic [15:0] alloc;
  logic [7:0] op;
  logic [15:0] sent;
  logic [15:0] limit;
  logic [7:0] sel_page;
  logic sel_ok;
  logic enable;
  logic [1:0] int_stat;
  logic [1:0] int_mask;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [15:0] avail;
  logic [15:0] next_sent;
  csd_byte_t page_byte;
  csd_byte_t desc_byte;
  logic cdb_take;
  logic din_take;
  logic wr_fire;
  logic done_ev;
  logic rej_ev;
  logic [1:0] ev;

  assign CDB_READY = (state == CSD_CMD);
  assign cdb_take = CDB_VALID & CDB_READY;
  assign din_take = DIN_VALID & DIN_READY;
  assign next_sent = sent + 16'h0001;

  // Only the supported list is held here; other pages would come from
  // the calibration logic, so their payload length is zero.
  always_comb
  begin
    avail = 16'h0000;
    if (sel_page == 8'h00)
      avail = `CSD_SUP_LEN;
  end

  // Supported diagnostics page contents.
  always_comb
  begin
    page_byte = 8'h00;
    case (sent[3:0])
      4'h0: page_byte = 8'h00;
      4'h1: page_byte = 8'h00;
      4'h2: page_byte = 8'h00;
      4'h3: page_byte = `CSD_SUP_PAGE_LEN;
      4'h4: page_byte = 8'h00;
      4'h5: page_byte = 8'h80;
      4'h6: page_byte = 8'h81;
      4'h7: page_byte = 8'h82;
      4'h8: page_byte = 8'h83;
      4'h9: page_byte = 8'h84;
      default: page_byte = 8'h00;
    endcase
  end

  // The page selected by the last completed send-diagnostic is kept.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sel_page <= 8'h00;
      sel_ok <= 1'b0;
    end
    else if (SENDDIAG_DONE)
    begin
      sel_page <= SENDDIAG_PAGE;
      sel_ok <= 1'b1;
    end
  end

  // Command byte capture.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cdb_cnt <= 3'd0;
      op <= 8'h00;
      alloc <= 16'h0000;
    end
    else if (state == CSD_IDLE)
      cdb_cnt <= 3'd0;
    else if (cdb_take)
    begin
      cdb_cnt <= cdb_cnt + 3'd1;
      if (cdb_cnt == 3'd0)
        op <= CDB_BYTE;
      else if (cdb_cnt == `CSD_CDB_ALLOC_HI)
        alloc[15:8] <= CDB_BYTE;
      else if (cdb_cnt == `CSD_CDB_ALLOC_LO)
        alloc[7:0] <= CDB_BYTE;
    end
  end

  // Command sequencer.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= CSD_IDLE;
      sent <= 16'h0000;
      limit <= 16'h0000;
      done_ev <= 1'b0;
      rej_ev <= 1'b0;
    end
    else
    begin
      done_ev <= 1'b0;
      rej_ev <= 1'b0;
      case (state)
        CSD_IDLE:
          if (enable)
            state <= CSD_CMD;
        CSD_CMD:
          if (cdb_take && cdb_cnt == `CSD_CDB_LEN - 3'd1)
          begin
            sent <= 16'h0000;
            limit <= (alloc < avail) ? alloc : avail;
            if (op != `CSD_OP_RDIAG || !sel_ok)
            begin
              rej_ev <= 1'b1;
              state <= CSD_IDLE;
            end
            else if (alloc == 16'h0000 || avail == 16'h0000)
            begin
              done_ev <= 1'b1;
              state <= CSD_IDLE;
            end
            else
              state <= CSD_DATA;
          end
        CSD_DATA:
          if (din_take)
          begin
            sent <= next_sent;
            if (next_sent == limit)
            begin
              done_ev <= 1'b1;
              state <= CSD_IDLE;
            end
          end
        default:
          state <= CSD_IDLE;
      endcase
    end
  end

  // Data byte is registered; the sequencer advances on acceptance.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DIN_VALID <= 1'b0;
      DIN_DATA <= 8'h00;
      DIN_LAST <= 1'b0;
    end
    else if (state == CSD_DATA && !(din_take && next_sent == limit))
    begin
      DIN_VALID <= 1'b1;
      DIN_DATA <= din_take ? page_byte_nxt(next_sent) : page_byte;
      DIN_LAST <= din_take ? (next_sent + 16'h0001 == limit)
                           : (sent + 16'h0001 == limit);
    end
    else
    begin
      DIN_VALID <= 1'b0;
      DIN_LAST <= 1'b0;
    end
  end

  function automatic csd_byte_t page_byte_nxt(input logic [15:0] i);
    csd_byte_t b;
    b = 8'h00;
    if (i[3:0] == 4'h3)
      b = `CSD_SUP_PAGE_LEN;
    else if (i[3:0] >= 4'h5 && i[3:0] <= 4'h9)
      b = 8'h80 + {4'h0, i[3:0] - 4'h5};
    return b;
  endfunction

  assign CMD_DONE = done_ev;
  assign CMD_REJECT = rej_ev;

  csd_desc u_desc (
    .idx(DESC_IDX),
    .elem_addr(ELEM_ADDR),
    .door_open(DOOR_OPEN),
    .mover_fault(MOVER_FAULT),
    .full(CART_PRESENT),
    .asc(FAULT_ASC),
    .ascq(FAULT_ASCQ),
    .src_valid(SRC_VALID),
    .src_addr(SRC_ADDR),
    .data(desc_byte)
  );

  // Descriptor byte is registered on request.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      DESC_DATA <= 8'h00;
    else if (DESC_REQ)
      DESC_DATA <= desc_byte;
  end

  // AXI write side: address and data are held until both are present.
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `CSD_RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (aw_addr == `CSD_ADDR_STAT) ? `CSD_RESP_SLVERR
                                                    : `CSD_RESP_OKAY;
      end
      else if (S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  assign ev = {rej_ev, done_ev};

  // Control, mask and sticky status; a new event wins over its clear.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      enable <= 1'b0;
      int_mask <= 2'b00;
      int_stat <= 2'b00;
    end
    else
    begin
      if (wr_fire && w_strb[0] && aw_addr == `CSD_ADDR_CTRL)
        enable <= w_data[0];
      if (wr_fire && w_strb[0] && aw_addr == `CSD_ADDR_INT_MASK)
        int_mask <= w_data[1:0];
      if (wr_fire && w_strb[0] && aw_addr == `CSD_ADDR_INT_STAT)
        int_stat <= (int_stat & ~w_data[1:0]) | ev;
      else
        int_stat <= int_stat | ev;
    end
  end

  assign IRQ = |(int_stat & int_mask);

  // AXI read side.
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= `CSD_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= `CSD_RESP_OKAY;
      if (S_AXI_ARADDR == `CSD_ADDR_CTRL)
        S_AXI_RDATA <= {31'h0, enable};
      else if (S_AXI_ARADDR == `CSD_ADDR_STAT)
        S_AXI_RDATA <= {14'h0, sel_ok, sel_page[0], limit};
      else if (S_AXI_ARADDR == `CSD_ADDR_INT_STAT)
        S_AXI_RDATA <= {30'h0, int_stat};
      else if (S_AXI_ARADDR == `CSD_ADDR_INT_MASK)
        S_AXI_RDATA <= {30'h0, int_mask};
      else
      begin
        S_AXI_RDATA <= 32'h0;
        S_AXI_RRESP <= `CSD_RESP_SLVERR;
      end
    end
    else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end
endmodule

// ---- test/csd_sva.sv ----
// Checker for data-in and descriptor outputs of csd_top.
// Bound into csd_top; sees its ports under their own names.
module csd_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic DIN_VALID,
  input wire logic [7:0] DIN_DATA,
  input wire logic DIN_LAST,
  input wire logic DIN_READY,
  input wire logic CMD_DONE,
  input wire logic CMD_REJECT,
  input wire logic DESC_REQ,
  input wire logic [3:0] DESC_IDX,
  input wire logic [7:0] DESC_DATA,
  input wire logic [15:0] ELEM_ADDR,
  input wire logic DOOR_OPEN,
  input wire logic MOVER_FAULT,
  input wire logic CART_PRESENT,
  input wire logic [7:0] FAULT_ASC
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  property p_hold;
    DIN_VALID && !DIN_READY |=> DIN_VALID && $stable(DIN_DATA);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held byte lost");
  property p_done;
    DIN_VALID && DIN_READY && DIN_LAST |=> CMD_DONE;
  endproperty
  a_done: assert property (p_done)
    else $error("no done after last byte");
  property p_rej;
    CMD_REJECT |-> !DIN_VALID && !CMD_DONE ##1 !CMD_REJECT;
  endproperty
  a_rej: assert property (p_rej)
    else $error("bad reject");
  property p_msb;
    DESC_REQ && DESC_IDX == 4'h0 |=> DESC_DATA == 8'($past(ELEM_ADDR) >> 8);
  endproperty
  a_msb: assert property (p_msb)
    else $error("address high byte");
  property p_lsb;
    DESC_REQ && DESC_IDX == 4'h1 |=> DESC_DATA == 8'($past(ELEM_ADDR));
  endproperty
  a_lsb: assert property (p_lsb)
    else $error("address low byte");
  property p_flags;
    DESC_REQ && DESC_IDX == 4'h2 |=> DESC_DATA == {4'h0, $past(DOOR_OPEN),
      $past(MOVER_FAULT), 1'b0, $past(CART_PRESENT) & !$past(MOVER_FAULT)};
  endproperty
  a_flags: assert property (p_flags)
    else $error("flag byte");
  property p_asc;
    DESC_REQ && DESC_IDX == 4'h4 |=>
      DESC_DATA == ($past(MOVER_FAULT) ? $past(FAULT_ASC) : 8'h00);
  endproperty
  a_asc: assert property (p_asc)
    else $error("sense code byte");
  property p_zero;
    DESC_REQ && DESC_IDX inside {3, 6, 7, 8, [12:15]} |=> DESC_DATA == 8'h00;
  endproperty
  a_zero: assert property (p_zero)
    else $error("fixed zero byte");
  c_done: cover property (CMD_DONE);
  c_rej: cover property (CMD_REJECT);
  c_stall: cover property (DIN_VALID && !DIN_READY);
endmodule

bind csd_top csd_sva u_sva (
  .CLK(CLK),
  .RST_N(RST_N),
  .DIN_VALID(DIN_VALID),
  .DIN_DATA(DIN_DATA),
  .DIN_LAST(DIN_LAST),
  .DIN_READY(DIN_READY),
  .CMD_DONE(CMD_DONE),
  .CMD_REJECT(CMD_REJECT),
  .DESC_REQ(DESC_REQ),
  .DESC_IDX(DESC_IDX),
  .DESC_DATA(DESC_DATA),
  .ELEM_ADDR(ELEM_ADDR),
  .DOOR_OPEN(DOOR_OPEN),
  .MOVER_FAULT(MOVER_FAULT),
  .CART_PRESENT(CART_PRESENT),
  .FAULT_ASC(FAULT_ASC)
);

// ---- test/csd_ini.sv ----
// Initiator model: sends six-byte command blocks, accepts data-in.
// Assumes one clock shared with the responder.
module csd_ini (
  input wire logic clk,
  input wire logic cdb_ready,
  output logic cdb_valid,
  output logic [7:0] cdb_byte,
  output logic din_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0;
  initial cdb_valid = 1'b0;
  initial cdb_byte = 8'h00;
  initial din_ready = 1'b0;
  // A slow initiator drops ready at random to stall the data-in phase.
  always @(posedge clk)
    din_ready <= slow ? 1'($urandom % 2) : 1'b1;
  task automatic send(input logic [7:0] op, input logic [15:0] len);
    logic [7:0] b [6];
    b = '{op, 8'h00, 8'h00, len[15:8], len[7:0], 8'h00};
    @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      cdb_valid <= 1'b1;
      cdb_byte <= b[i];
      do @(negedge clk); while (!cdb_ready);
      @(posedge clk);
    end
    cdb_valid <= 1'b0;
    cdb_byte <= ~b[5];
  endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for csd_top with a scoreboard queue.
// Assumes the initiator model and the bound checker are compiled.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RST_N = 1'b0;
  logic CDB_VALID, CDB_READY, DIN_VALID, DIN_LAST, DIN_READY, CMD_DONE;
  logic CMD_REJECT, IRQ, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID;
  logic [7:0] CDB_BYTE, DIN_DATA, DESC_DATA;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic SENDDIAG_DONE = 1'b0, DESC_REQ = 1'b0, DOOR_OPEN = 1'b0;
  logic MOVER_FAULT = 1'b0, CART_PRESENT = 1'b0, SRC_VALID = 1'b0;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, dq = 1'b0;
  logic [3:0] DESC_IDX = 4'h0, S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic [7:0] SENDDIAG_PAGE = 8'h00, FAULT_ASC = 8'h00, FAULT_ASCQ = 8'h00;
  logic [15:0] ELEM_ADDR = 16'h0000, SRC_ADDR = 16'h0000;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [7:0] pg [10] = '{8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'h80, 8'h81,
    8'h82, 8'h83, 8'h84};
  logic [36:0] q [$];
  int fail_count = 0, n_compared = 0;
  csd_top uut (.CLK(CLK), .RST_N(RST_N), .CDB_VALID(CDB_VALID),
    .CDB_BYTE(CDB_BYTE), .CDB_READY(CDB_READY), .DIN_VALID(DIN_VALID),
    .DIN_DATA(DIN_DATA), .DIN_LAST(DIN_LAST), .DIN_READY(DIN_READY),
    .CMD_DONE(CMD_DONE), .CMD_REJECT(CMD_REJECT),
    .SENDDIAG_DONE(SENDDIAG_DONE), .SENDDIAG_PAGE(SENDDIAG_PAGE),
    .DESC_REQ(DESC_REQ), .DESC_IDX(DESC_IDX), .DESC_DATA(DESC_DATA),
    .ELEM_ADDR(ELEM_ADDR), .DOOR_OPEN(DOOR_OPEN),
    .MOVER_FAULT(MOVER_FAULT), .CART_PRESENT(CART_PRESENT),
    .FAULT_ASC(FAULT_ASC), .FAULT_ASCQ(FAULT_ASCQ), .SRC_VALID(SRC_VALID),
    .SRC_ADDR(SRC_ADDR), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .IRQ(IRQ));
  csd_ini u_ini (.clk(CLK), .cdb_ready(CDB_READY), .cdb_valid(CDB_VALID),
    .cdb_byte(CDB_BYTE), .din_ready(DIN_READY));
  initial forever #2 CLK = ~CLK;
  task automatic chk(input string n, input logic [36:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  // An event with nothing queued is compared against all ones and fails.
  task automatic look(input string n, input logic [36:0] got);
    chk(n, got, q.size() > 0 ? q.pop_front() : 37'h1fffffffff);
  endtask
  always @(posedge CLK)
  begin
    dq <= DESC_REQ;
    if (DIN_VALID && DIN_READY)
      look("din", {4'h0, DIN_LAST, 24'h0, DIN_DATA});
    if (CMD_DONE)
      look("done", {3'h1, 34'h0});
    if (CMD_REJECT)
      look("reject", {3'h2, 34'h0});
    if (S_AXI_BVALID && S_AXI_BREADY)
      look("bresp", {3'h3, S_AXI_BRESP, 32'h0});
    if (S_AXI_RVALID && S_AXI_RREADY)
      look("rdata", {3'h4, S_AXI_RRESP, S_AXI_RDATA});
    if (dq)
      look("desc", {3'h5, 26'h0, DESC_DATA});
  end
  task automatic fin(input string n);
    for (int i = 0; i < 400 && q.size() > 0; i++)
      @(posedge CLK);
    if (q.size() > 0)
    begin
      fail_count++;
      $display("MISMATCH %s expected event seen none", n);
      q.delete();
    end
    $display("test %s done", n);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    q.push_back({3'h3, r[1:0], 32'h0});
    @(posedge CLK);
    {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    while (pa || pw)
    begin
      @(negedge CLK);
      pa = pa && !S_AXI_AWREADY;
      pw = pw && !S_AXI_WREADY;
      @(posedge CLK);
      {S_AXI_AWVALID, S_AXI_WVALID} <= {pa, pw};
    end
    while (!S_AXI_BVALID)
      @(negedge CLK);
    @(posedge CLK);
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d);
    q.push_back({3'h4, 2'h0, d});
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do @(negedge CLK); while (!S_AXI_ARREADY);
    @(posedge CLK);
    S_AXI_ARVALID <= 1'b0;
    do @(negedge CLK); while (!S_AXI_RVALID);
    @(posedge CLK);
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic irq(input logic e);
    @(negedge CLK);
    chk("irq", {36'h0, IRQ}, {36'h0, e});
  endtask
  task automatic sdiag(input logic [7:0] p);
    @(posedge CLK);
    {SENDDIAG_PAGE, SENDDIAG_DONE} <= {p, 1'b1};
    @(posedge CLK);
    SENDDIAG_DONE <= 1'b0;
  endtask
  // Kind 0 expects a reject, 1 a bare done, 2 page bytes then done.
  task automatic cmd(input string n, input logic [7:0] op,
    input logic [15:0] len, input int kind);
    int k;
    k = kind < 2 ? 0 : (len < 10 ? len : 10);
    for (int i = 0; i < k; i++)
      q.push_back({4'h0, 1'(i == k - 1), 24'h0, pg[i]});
    q.push_back({kind == 0 ? 3'h2 : 3'h1, 34'h0});
    u_ini.send(op, len);
    fin(n);
  endtask
  task automatic desc(input logic f, input logic [7:0] c, cq);
    logic [15:0] ea, sa;
    logic [2:0] s;
    logic [7:0] e;
    {ea, sa, s} = {16'($urandom), 16'($urandom), 3'($urandom)};
    @(posedge CLK);
    {ELEM_ADDR, SRC_ADDR, DOOR_OPEN, CART_PRESENT, SRC_VALID} <= {ea, sa, s};
    {MOVER_FAULT, FAULT_ASC, FAULT_ASCQ} <= {f, c, cq};
    for (int i = 0; i < 16; i++)
    begin
      case (i)
        0: e = ea[15:8];
        1: e = ea[7:0];
        2: e = {4'h0, s[2], f, 1'b0, s[1] & !f};
        4: e = f ? c : 8'h00;
        5: e = f ? cq : 8'h00;
        9: e = {s[0], 7'h0};
        10: e = sa[15:8];
        11: e = sa[7:0];
        default: e = 8'h00;
      endcase
      q.push_back({3'h5, 26'h0, e});
      {DESC_REQ, DESC_IDX} <= {1'b1, 4'(i)};
      @(posedge CLK);
    end
    DESC_REQ <= 1'b0;
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(69));
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    desc(1'b0, 8'h00, 8'h00);
    desc(1'b1, 8'h90, 8'h02);
    desc(1'b1, 8'h90, 8'h03);
    fin("descriptor");
    wr(4'h0, 32'h1, 2'h0);
    rd(4'h0, 32'h1);
    wr(4'h4, 32'h0, 2'h2);
    cmd("noprior", 8'h1c, 16'h000a, 0);
    rd(4'h8, 32'h2);
    irq(1'b0);
    wr(4'hc, 32'h3, 2'h0);
    irq(1'b1);
    wr(4'h8, 32'h2, 2'h0);
    irq(1'b0);
    sdiag(8'h00);
    cmd("badop", 8'h12, 16'h000a, 0);
    cmd("zero", 8'h1c, 16'h0000, 1);
    cmd("part", 8'h1c, 16'(1 + $urandom % 9), 2);
    u_ini.slow = 1'b1;
    cmd("full", 8'h1c, 16'h000a, 2);
    cmd("over", 8'h1c, 16'h0105, 2);
    u_ini.slow = 1'b0;
    rd(4'h8, 32'h3);
    sdiag(8'h80);
    cmd("page80", 8'h1c, 16'h0020, 1);
    // Status shows a completed selection of page 80h and an empty limit.
    rd(4'h4, 32'h0002_0000);
    summarize();
  end
  initial
  begin
    #80000;
    fail_count++;
    $display("MISMATCH watchdog expected finish seen hang");
    summarize();
  end
endmodule
